// File: rtl/alu_core.sv
// arithmetic and logic datapath: byte ops in one clock, word ops in two
// assumes the decoder holds op_valid only while busy is low is honoured
`timescale 1ns/10ps
`default_nettype none
`include "alu_regs.svh"

module alu_core
(
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               op_valid,
    input  wire alu_pkg::alu_op_e   op_code,
    input  wire alu_pkg::alu_byte_t dst_value,
    input  wire alu_pkg::alu_byte_t dst_high,
    input  wire alu_pkg::alu_byte_t source_register,
    input  wire alu_pkg::alu_byte_t flags_in,
    output alu_pkg::alu_byte_t      result_low,
    output alu_pkg::alu_byte_t      result_high,
    output logic                    result_valid,
    output logic                    result_is_word,
    output alu_pkg::alu_byte_t      flags_out,
    output logic                    busy
);

    // zero, negative and overflow after a logic op
    function automatic alu_pkg::alu_byte_t logic_flags
        (input alu_pkg::alu_byte_t base, input alu_pkg::alu_byte_t res);
        alu_pkg::alu_byte_t f;
        f = base;
        f[`ALU_FLAG_Z] = (res == `ALU_BYTE_ZERO);
        f[`ALU_FLAG_N] = res[`ALU_SIGN_BIT];
        f[`ALU_FLAG_V] = 1'b0;
        return f;
    endfunction
    // zero, carry, negative, overflow and half carry after arithmetic
    function automatic alu_pkg::alu_byte_t arith_flags
        (input alu_pkg::alu_byte_t base, input alu_pkg::alu_byte_t res,
         input logic c, input logic h, input logic v);
        alu_pkg::alu_byte_t f;
        f = base;
        f[`ALU_FLAG_Z] = (res == `ALU_BYTE_ZERO);
        f[`ALU_FLAG_N] = res[`ALU_SIGN_BIT];
        f[`ALU_FLAG_V] = v;
        f[`ALU_FLAG_C] = c;
        f[`ALU_FLAG_H] = h;
        return f;
    endfunction
    logic               rst_meta;
    logic               rst_sync_n;
    alu_pkg::alu_state_e state;
    alu_pkg::alu_state_e next_state;
    alu_pkg::alu_byte_t  hold_high;
    alu_pkg::alu_byte_t  next_hold_high;
    alu_pkg::alu_byte_t  hold_flags;
    alu_pkg::alu_byte_t  next_hold_flags;
    logic                hold_carry;
    logic                next_hold_carry;
    logic                hold_sub;
    logic                next_hold_sub;
    alu_pkg::alu_byte_t  next_result_low;
    alu_pkg::alu_byte_t  next_result_high;
    logic                next_result_valid;
    logic                next_result_is_word;
    alu_pkg::alu_byte_t  next_flags_out;
    logic                next_busy;
    logic                add_sub;
    alu_pkg::alu_byte_t  add_a;
    alu_pkg::alu_byte_t  add_b;
    logic                add_cin;
    alu_pkg::alu_byte_t  add_sum;
    logic                add_cout;
    logic                add_half;
    logic                add_ovf;
    logic                carry_now;
    // reset release through two flops
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            {rst_sync_n, rst_meta} <= 2'b00;
        else
            {rst_sync_n, rst_meta} <= {rst_meta, 1'b1};
    end

    assign carry_now = flags_in[`ALU_FLAG_C];
    // adder operand selection
    always_comb
    begin
        add_sub = 1'b0;
        add_a   = dst_value;
        add_b   = source_register;
        add_cin = 1'b0;
        if (state == alu_pkg::st_word_high)
        begin
            // high byte only takes the low byte carry or borrow
            add_sub = hold_sub; // see RL2 // see RL5
            add_a   = hold_high;
            add_b   = `ALU_BYTE_ZERO;
            add_cin = hold_carry;
        end
        else
        begin
            case (op_code)
                alu_pkg::op_add_carry:
                    add_cin = carry_now; // see RL1
                alu_pkg::op_sub,
                alu_pkg::op_subtract_constant:
                    add_sub = 1'b1; // see RL3
                alu_pkg::op_subtract_with_borrow,
                alu_pkg::op_subtract_borrow_immediate:
                begin
                    add_sub = 1'b1; // see RL4
                    add_cin = carry_now;
                end
                alu_pkg::op_word_subtract_immediate:
                    add_sub = 1'b1; // see RL5
                alu_pkg::op_arithmetic_sign_flip:
                begin
                    add_sub = 1'b1; // see RL10
                    add_a   = `ALU_BYTE_ZERO;
                    add_b   = dst_value;
                end
                alu_pkg::op_increment:
                    add_b   = `ALU_BYTE_ONE; // see RL10
                default:
                    add_sub = 1'b0;
            endcase
        end
    end
    alu_add8 u_add
    (
        .subtract  (add_sub),
        .a         (add_a),
        .b         (add_b),
        .carry_in  (add_cin),
        .sum       (add_sum),
        .carry_out (add_cout),
        .half_out  (add_half),
        .overflow  (add_ovf)
    );
    // next state, results and flags
    always_comb
    begin
        alu_pkg::alu_byte_t f;
        alu_pkg::alu_byte_t r;
        f = flags_in;
        r = `ALU_BYTE_ZERO;
        next_state          = state;
        next_hold_high      = hold_high;
        next_hold_flags     = hold_flags;
        next_hold_carry     = hold_carry;
        next_hold_sub       = hold_sub;
        next_result_low     = result_low;
        next_result_high    = result_high;
        next_result_valid   = 1'b0;
        next_result_is_word = result_is_word;
        next_flags_out      = flags_out;
        next_busy           = 1'b0;
        case (state)
            alu_pkg::st_idle:
            begin
                if (op_valid)
                begin
                    next_result_valid   = 1'b1;
                    case (op_code)
                        alu_pkg::op_add,
                        alu_pkg::op_add_carry,
                        alu_pkg::op_sub,
                        alu_pkg::op_subtract_constant,
                        alu_pkg::op_arithmetic_sign_flip: // see RL10
                        begin
                            r = add_sum; // see RL1 // see RL3
                            f = arith_flags(flags_in, r, add_cout,
                                            add_half, add_ovf);
                        end
                        alu_pkg::op_subtract_with_borrow,
                        alu_pkg::op_subtract_borrow_immediate:
                        begin
                            r = add_sum; // see RL4
                            f = arith_flags(flags_in, r, add_cout,
                                            add_half, add_ovf);
                            // zero only stays set across a chain
                            f[`ALU_FLAG_Z] = f[`ALU_FLAG_Z]
                                           & flags_in[`ALU_FLAG_Z];
                        end
                        alu_pkg::op_word_add_immediate,
                        alu_pkg::op_word_subtract_immediate:
                        begin
                            // low byte now, high byte next clock
                            next_result_valid = 1'b0; // see RL2 // see RL5
                            next_result_low   = add_sum;
                            next_hold_high    = dst_high;
                            next_hold_flags   = flags_in;
                            next_hold_carry   = add_cout;
                            next_hold_sub     = add_sub;
                            next_busy         = 1'b1;
                            next_state        = alu_pkg::st_word_high;
                        end
                        alu_pkg::op_and,
                        alu_pkg::op_logical_and_immediate:
                        begin
                            r = dst_value & source_register; // see RL6
                            f = logic_flags(flags_in, r);
                        end
                        alu_pkg::op_or,
                        alu_pkg::op_or_immediate,
                        alu_pkg::op_set_bits_mask: // see RL8
                        begin
                            r = dst_value | source_register; // see RL7
                            f = logic_flags(flags_in, r);
                        end
                        alu_pkg::op_exclusive_or:
                        begin
                            r = dst_value ^ source_register; // see RL7
                            f = logic_flags(flags_in, r);
                        end
                        alu_pkg::op_clear_bits_mask:
                        begin
                            r = dst_value
                              & (`ALU_BYTE_ONES ^ source_register); // see RL9
                            f = logic_flags(flags_in, r);
                        end
                        alu_pkg::op_bitwise_invert:
                        begin
                            r = `ALU_BYTE_ONES ^ dst_value; // see RL10
                            f = logic_flags(flags_in, r);
                            f[`ALU_FLAG_C] = 1'b1;
                        end
                        alu_pkg::op_increment:
                        begin
                            r = add_sum; // see RL10
                            f = logic_flags(flags_in, r);
                            f[`ALU_FLAG_V] = add_ovf;
                        end
                        default:
                            next_result_valid = 1'b0;
                    endcase
                    if (next_result_valid)
                    begin
                        next_result_low     = r;
                        next_flags_out      = f;
                        next_result_is_word = 1'b0;
                    end
                end
            end
            alu_pkg::st_word_high:
            begin
                f = hold_flags; // see RL2 // see RL5
                f[`ALU_FLAG_Z] = (add_sum == `ALU_BYTE_ZERO)
                               & (result_low == `ALU_BYTE_ZERO);
                f[`ALU_FLAG_N] = add_sum[`ALU_SIGN_BIT];
                f[`ALU_FLAG_V] = add_ovf;
                f[`ALU_FLAG_C] = add_cout;
                f[`ALU_FLAG_S] = add_sum[`ALU_SIGN_BIT] ^ add_ovf;
                next_flags_out      = f;
                next_result_high    = add_sum;
                next_result_valid   = 1'b1;
                next_result_is_word = 1'b1;
                next_state          = alu_pkg::st_idle;
            end
            default:
                next_state = alu_pkg::st_idle;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state          <= alu_pkg::st_idle;
            hold_high      <= `ALU_BYTE_ZERO;
            hold_flags     <= `ALU_FLAGS_RESET;
            hold_carry     <= 1'b0;
            hold_sub       <= 1'b0;
            result_low     <= `ALU_BYTE_ZERO;
            result_high    <= `ALU_BYTE_ZERO;
            result_valid   <= 1'b0;
            result_is_word <= 1'b0;
            flags_out      <= `ALU_FLAGS_RESET;
            busy           <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            hold_high      <= next_hold_high;
            hold_flags     <= next_hold_flags;
            hold_carry     <= next_hold_carry;
            hold_sub       <= next_hold_sub;
            result_low     <= next_result_low;
            result_high    <= next_result_high;
            result_valid   <= next_result_valid;
            result_is_word <= next_result_is_word;
            flags_out      <= next_flags_out;
            busy           <= next_busy;
        end
    end

endmodule // alu_core
`default_nettype wire

// File: rtl/alu_regs.svh
// constants of the 8-bit arithmetic and logic datapath
// assumes the includer works on 8-bit bytes and an 8-bit status byte
//
// How it works
// RL1: add and add-with-carry, five flags, one clock
// RL2: word add constant to pair, two clocks
// RL3: subtract register or constant, one clock
// RL4: subtract with borrow, register or constant
// RL5: word subtract constant from pair, two clocks
// RL6: and with register or constant, Z N V
// RL7: or, or constant, exclusive-or; Z N V
// RL8: set bits by mask, Z N V only
// RL9: clear bits by inverted mask, Z N V
// RL10: invert, sign flip, increment, one clock each
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

// status byte bit positions
`define ALU_FLAG_C      0
`define ALU_FLAG_Z      1
`define ALU_FLAG_N      2
`define ALU_FLAG_V      3
`define ALU_FLAG_S      4
`define ALU_FLAG_H      5
`define ALU_FLAG_T      6
`define ALU_FLAG_I      7

// byte values
`define ALU_BYTE_ZERO   8'h00
`define ALU_BYTE_ONE    8'h01
`define ALU_BYTE_ONES   8'hff
`define ALU_FLAGS_RESET 8'h00
`define ALU_SIGN_BIT    7
`define ALU_NIBBLE_TOP  3

`endif

// File: rtl/alu_pkg.sv
// types shared by the datapath modules
// assumes the decoder hands over one of these codes per operation
package alu_pkg;

    typedef enum logic [4:0] {
        op_add,
        op_add_carry,
        op_word_add_immediate,
        op_sub,
        op_subtract_constant,
        op_subtract_with_borrow,
        op_subtract_borrow_immediate,
        op_word_subtract_immediate,
        op_and,
        op_logical_and_immediate,
        op_or,
        op_or_immediate,
        op_exclusive_or,
        op_bitwise_invert,
        op_arithmetic_sign_flip,
        op_set_bits_mask,
        op_clear_bits_mask,
        op_increment
    } alu_op_e;

    typedef enum {
        st_idle,
        st_word_high
    } alu_state_e;

    typedef logic [7:0] alu_byte_t;

endpackage

// File: rtl/alu_add8.sv
// 8-bit adder/subtractor with carry, half carry and overflow
// assumes operands are stable within the cycle; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "alu_regs.svh"

module alu_add8
(
    input  wire logic            subtract,
    input  wire alu_pkg::alu_byte_t a,
    input  wire alu_pkg::alu_byte_t b,
    input  wire logic            carry_in,
    output alu_pkg::alu_byte_t   sum,
    output logic                 carry_out,
    output logic                 half_out,
    output logic                 overflow
);

    logic [8:0] full;
    logic [4:0] low;
    logic       a7;
    logic       b7;
    logic       r7;

    always_comb
    begin
        if (subtract)
        begin
            // carry_out is the borrow
            full = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
            low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, carry_in};
        end
        else
        begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
            low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
        end
        sum       = full[7:0];
        carry_out = full[8];
        half_out  = low[4];
        a7        = a[`ALU_SIGN_BIT];
        b7        = b[`ALU_SIGN_BIT];
        r7        = full[`ALU_SIGN_BIT];
        if (subtract)
            overflow = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
        else
            overflow = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
    end

endmodule // alu_add8
`default_nettype wire

// File: sim/alu_core_monitor.sv
// assertions on the datapath ports, bound onto alu_core
// assumes one clock and the active low reset seen at the top ports
`timescale 1ns/10ps
`default_nettype none
module alu_core_monitor
(
    input wire logic               mclk,
    input wire logic               reset_n,
    input wire logic               op_valid,
    input wire alu_pkg::alu_op_e   op_code,
    input wire alu_pkg::alu_byte_t dst_value,
    input wire alu_pkg::alu_byte_t dst_high,
    input wire alu_pkg::alu_byte_t source_register,
    input wire alu_pkg::alu_byte_t flags_in,
    input wire alu_pkg::alu_byte_t result_low,
    input wire alu_pkg::alu_byte_t result_high,
    input wire logic               result_valid,
    input wire logic               result_is_word,
    input wire alu_pkg::alu_byte_t flags_out,
    input wire logic               busy
);
    logic acc;
    logic is_word;
    logic is_logic;
    assign acc = op_valid && !busy;
    assign is_word = op_code inside {alu_pkg::op_word_add_immediate,
        alu_pkg::op_word_subtract_immediate};
    assign is_logic = op_code inside {alu_pkg::op_and, alu_pkg::op_or,
        alu_pkg::op_logical_and_immediate, alu_pkg::op_or_immediate,
        alu_pkg::op_exclusive_or, alu_pkg::op_set_bits_mask,
        alu_pkg::op_clear_bits_mask};

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_byte;
        acc && !is_word && op_code <= alu_pkg::op_increment
            |=> result_valid && !result_is_word && !busy;
    endproperty
    a_byte: assert property (p_byte) else $error("byte late");
    property p_word;
        acc && is_word |=> busy && !result_valid
            ##1 !busy && result_valid && result_is_word;
    endproperty
    a_word: assert property (p_word) else $error("word timing");
    property p_add;
        acc && op_code == alu_pkg::op_add |=> {flags_out[0], result_low}
            == $past(dst_value) + $past(source_register);
    endproperty
    a_add: assert property (p_add) else $error("add sum wrong");
    property p_sbc;
        acc && op_code == alu_pkg::op_subtract_with_borrow |=> result_low
            == $past(dst_value) - $past(source_register) - $past(flags_in[0])
            && (!flags_out[1] || $past(flags_in[1]));
    endproperty
    a_sbc: assert property (p_sbc) else $error("borrow sub wrong");
    property p_wadd;
        acc && op_code == alu_pkg::op_word_add_immediate |-> ##2
            {flags_out[0], result_high, result_low} == {$past(dst_high, 2),
            $past(dst_value, 2)} + $past(source_register, 2);
    endproperty
    a_wadd: assert property (p_wadd) else $error("word sum wrong");
    property p_logic;
        acc && is_logic |=> !flags_out[3] && flags_out[2] == result_low[7]
            && flags_out[1] == (result_low == 8'h00);
    endproperty
    a_logic: assert property (p_logic) else $error("logic op");
    property p_clear;
        acc && op_code == alu_pkg::op_clear_bits_mask |=> result_low
            == ($past(dst_value) & ~$past(source_register));
    endproperty
    a_clear: assert property (p_clear) else $error("clear bits");
    property p_inv;
        acc && op_code == alu_pkg::op_bitwise_invert
        |=> result_low == ~$past(dst_value) && flags_out[0] && !flags_out[3];
    endproperty
    a_inv: assert property (p_inv) else $error("invert wrong");
    c_word: cover property (acc && is_word ##2 result_valid);
    c_refused: cover property (busy && op_valid);
    c_b2b: cover property (result_valid ##1 result_valid);
endmodule // alu_core_monitor

bind alu_core alu_core_monitor i_mon
(
    .mclk(mclk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
    .dst_value(dst_value), .dst_high(dst_high), .flags_in(flags_in),
    .source_register(source_register), .result_low(result_low),
    .result_high(result_high), .result_valid(result_valid),
    .result_is_word(result_is_word), .flags_out(flags_out), .busy(busy)
);
`default_nettype wire

// File: sim/alu_flag_store.sv
// status byte holder of the core, feeding flags_in from flags_out
// assumes the bench may overwrite the byte together with a request
`timescale 1ns/10ps
`default_nettype none
module alu_flag_store
(
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               load,
    input  wire alu_pkg::alu_byte_t load_value,
    input  wire logic               result_valid,
    input  wire alu_pkg::alu_byte_t flags_out,
    output alu_pkg::alu_byte_t      flags
);
    alu_pkg::alu_byte_t held;

    // a fresh result is passed straight on for back to back ops
    always_comb
    begin
        flags = load ? load_value : (result_valid ? flags_out : held);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            held <= 8'h00;
        else
            held <= flags;
    end
endmodule // alu_flag_store
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench: random ops compared with an integer model
// assumes alu_core, alu_flag_store and the bound monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic               mclk;
    logic               reset_n;
    logic               op_valid;
    logic               load;
    logic               result_valid;
    logic               result_is_word;
    logic               busy;
    logic               busy_m;
    alu_pkg::alu_op_e   op_code;
    alu_pkg::alu_byte_t dst_value;
    alu_pkg::alu_byte_t dst_high;
    alu_pkg::alu_byte_t source_register;
    alu_pkg::alu_byte_t flags_in;
    alu_pkg::alu_byte_t load_value;
    alu_pkg::alu_byte_t result_low;
    alu_pkg::alu_byte_t result_high;
    alu_pkg::alu_byte_t flags_out;
    alu_pkg::alu_byte_t flags_ref;
    logic [31:0]        rnd;
    logic [24:0]        got;
    logic [24:0]        e;
    logic [24:0]        exp_q[$];
    int                 bad_count;
    int                 checks;

    alu_core i_dut
    (
        .mclk(mclk), .reset_n(reset_n), .op_valid(op_valid),
        .op_code(op_code), .dst_value(dst_value), .dst_high(dst_high),
        .source_register(source_register), .flags_in(flags_in),
        .result_low(result_low), .result_high(result_high),
        .result_valid(result_valid), .result_is_word(result_is_word),
        .flags_out(flags_out), .busy(busy)
    );
    alu_flag_store i_flags
    (
        .mclk(mclk), .reset_n(reset_n), .load(load),
        .load_value(load_value), .result_valid(result_valid),
        .flags_out(flags_out), .flags(flags_in)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic alu_pkg::alu_byte_t pick(input logic [3:0] s,
        input alu_pkg::alu_byte_t v);
        case (s)
            4'h0: return 8'h00;
            4'h1: return 8'h0f;
            4'h2: return 8'h7f;
            4'h3: return 8'h80;
            4'h4: return 8'hff;
            default: return v;
        endcase
    endfunction

    // {word, flags, high, low}
    function automatic logic [24:0] model(input alu_pkg::alu_op_e op,
        input int d, input int h, input int k, input logic [7:0] f);
        int         a;
        int         b;
        int         c;
        int         x;
        int         r;
        logic       sb;
        logic       bw;
        logic       ar;
        logic [7:0] o;
        o = f;
        a = d;
        b = k;
        x = 0;
        ar = 0;
        bw = op inside {alu_pkg::op_subtract_with_borrow,
            alu_pkg::op_subtract_borrow_immediate};
        sb = bw || op inside {alu_pkg::op_sub, alu_pkg::op_subtract_constant,
            alu_pkg::op_arithmetic_sign_flip,
            alu_pkg::op_word_subtract_immediate};
        c = (bw || op == alu_pkg::op_add_carry) ? f[0] : 0;
        if (op == alu_pkg::op_arithmetic_sign_flip)
        begin
            a = 0;
            b = d;
        end
        case (op)
            alu_pkg::op_and, alu_pkg::op_logical_and_immediate: x = d & k;
            alu_pkg::op_or, alu_pkg::op_or_immediate,
            alu_pkg::op_set_bits_mask: x = d | k;
            alu_pkg::op_exclusive_or: x = d ^ k;
            alu_pkg::op_clear_bits_mask: x = d & (255 - k);
            alu_pkg::op_bitwise_invert: x = 255 - d;
            alu_pkg::op_increment: x = (d + 1) & 255;
            default: ar = 1;
        endcase
        if (op inside {alu_pkg::op_word_add_immediate,
            alu_pkg::op_word_subtract_immediate})
        begin
            a = h * 256 + d;
            x = sb ? a - k : a + k;
            r = x & 65535;
            o[0] = x[16];
            o[1] = r == 0;
            o[2] = r[15];
            o[3] = sb ? a[15] && !r[15] : !a[15] && r[15];
            o[4] = o[2] ^ o[3];
            return {1'b1, o, r[15:0]};
        end
        if (ar)
        begin
            x = sb ? a - b - c : a + b + c;
            r = x & 255;
            o[0] = x[8];
            o[5] = sb ? (a & 15) < (b & 15) + c : (a & 15) + (b & 15) + c > 15;
            o[3] = (a[7] ^ b[7] ^ !sb) && r[7] != a[7];
        end
        else
        begin
            r = x;
            o[3] = op == alu_pkg::op_increment && r == 128;
            o[0] = o[0] || op == alu_pkg::op_bitwise_invert;
        end
        o[1] = r == 0 && (!bw || f[1]);
        o[2] = r[7];
        return {1'b0, o, 8'h00, r[7:0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want,
        input string what);
        checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // account for what the edge took, then drive the next request
    task automatic step(input logic more);
        if (load)
            flags_ref = load_value;
        if (op_valid && !busy_m && op_code <= alu_pkg::op_increment)
        begin
            got = model(op_code, dst_value, dst_high, source_register,
                flags_ref);
            exp_q.push_back(got);
            flags_ref = got[23:16];
            busy_m = got[24];
        end
        else
            busy_m = 1'b0;
        repeat (8)
            rnd = lfsr(rnd);
        op_valid <= more && rnd[2:0] != 3'h0;
        op_code <= alu_pkg::alu_op_e'(rnd[7:3] % 20);
        dst_value <= pick(rnd[11:8], rnd[31:24]);
        dst_high <= pick(rnd[15:12], rnd[23:16]);
        source_register <= pick(rnd[19:16], rnd[27:20]);
        load <= more && !busy_m && rnd[22:20] == 3'h0;
        load_value <= rnd[30:23];
    endtask

    always @(negedge mclk)
    begin
        if (reset_n === 1'b1)
            check(busy, busy_m, "busy");
        if (reset_n === 1'b1 && result_valid === 1'b1)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check(result_low, e[7:0], "result_low");
            check(flags_out, e[23:16], "flags_out");
            check(result_is_word, e[24], "result_is_word");
            if (e[24] === 1'b1)
                check(result_high, e[15:8], "result_high");
        end
    end

    initial
    begin
        mclk = 1'b0;
        forever
            #4 mclk = ~mclk;
    end

    initial
    begin
        reset_n = 1'b0;
        op_valid = 1'b0;
        op_code = alu_pkg::op_add;
        dst_value = 8'h00;
        dst_high = 8'h00;
        source_register = 8'h00;
        load = 1'b0;
        load_value = 8'h00;
        flags_ref = 8'h00;
        busy_m = 1'b0;
        rnd = 32'h04c5;
        bad_count = 0;
        checks = 0;
        repeat (12)
            @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3)
            @(posedge mclk);
        @(negedge mclk);
        check(flags_out, 8'h00, "flags_out after reset");
        check(result_valid, 1'b0, "result_valid after reset");
        for (int n = 0; n < 6000; n++)
        begin
            @(posedge mclk);
            step(n < 5996);
        end
        check(exp_q.size(), 0, "results outstanding");
        reset_n <= 1'b0;
        @(negedge mclk);
        check(result_low, 8'h00, "result_low in reset");
        check(flags_out, 8'h00, "flags_out in reset");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
